/* core/frsg_core.sv */
/*
  Resume and sector guard logic of a serial flash: shifts in frames on the
  serial link clock, hands each completed frame to the system clock,
  runs the resume sequencing and the write-protect guard state.
  Assumes sclk only toggles while cs_n is low; the array engine that
  performs program and erase sits outside and reports through ports.
*/
// How it works
// - resume is single byte D0, up to three more bytes ignored
// - resume starts within resume latency after deselect
// - resume clears its suspend flag, shows busy
// - program resumes before erase when both suspended
// - suspend ignored while resume takes effect
// - guarded sectors come from protection register
// - status reports protection enabled, either source
// - write-protect pin reads high when floating
// - software protection clears on power cycle
// - 3D 2A 7F A9 enables at deselect
// - 3D 2A 7F 9A disables at deselect
// - pin low refuses guarded sectors and register
// - pin low enables guard within latency
// - pin release drops guard only without command
// - disable ignored while pin is low
// - pin guards sectors and locks register
// - pin filtered against brief glitches
// - register byte FF protected, 00 open
`timescale 1ns/1ps
module frsg_core
  import frsg_pkg::*;
#(
  parameter int RESUME_CYC = FRSG_RESUME_CYC
) (
  input  wire logic                  mclk_in,          // system clock 125 MHz
  input  wire logic                  srst_in,          // sync reset, high
  input  wire logic                  sclk_in,          // serial link clock
  input  wire logic                  cs_n_in,          // chip select, low active
  input  wire logic                  si_in,            // serial data in
  input  wire logic                  wp_n_in,          // write protect pin, low active
  input  wire logic                  wp_n_pulled_in,   // pad pull-up present, high
  input  wire logic                  prog_susp_a_in,   // array: program a suspended
  input  wire logic                  prog_susp_b_in,   // array: program b suspended
  input  wire logic                  erase_susp_in,    // array: erase suspended
  input  wire logic                  op_done_in,       // array: resumed op finished
  input  wire logic [5:0]            sect_addr_in,     // sector of a pending write
  input  wire logic [7:0]            sect_byte_in,     // its protection register byte
  input  wire logic                  spr_write_in,     // pending write targets register
  output logic                       resume_prog_out,  // pulse: resume program
  output logic                       resume_erase_out, // pulse: resume erase
  output logic                       suspend_out,      // pulse: accepted suspend
  output logic                       write_refused_out,// pending write refused
  output frsg_pkg::frsg_status_type  status_out        // status register bits
);
  import frsg_pkg::*;

  // ==========================================================
  // link domain: shift bytes, keep the first four of a frame
  logic [7:0]  sh_reg;
  logic [2:0]  bit_reg;
  logic [2:0]  nbytes_reg;
  logic [31:0] frame_reg;
  logic        fresh_reg;
  logic [7:0]  byte_next;

  assign byte_next = {sh_reg[6:0], si_in};

  // cs_n high only marks the next sclk rise as a frame start; the counts
  // must survive the deselect, since the system clock decodes them later
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  // limitation: a frame with no sclk at all leaves the old counts, so
  // the previous command would be decoded again; hosts never send one
  always_ff @(posedge sclk_in) begin
    if (fresh_reg) begin
      bit_reg    <= 3'h1;
      nbytes_reg <= 3'h0;
      sh_reg     <= {7'h00, si_in};
    end else begin
      sh_reg  <= byte_next;
      bit_reg <= bit_reg + 3'h1;
      if (bit_reg == 3'h7 && nbytes_reg != 3'h5) begin
        nbytes_reg <= nbytes_reg + 3'h1;
      end
    end
  end

  // bytes beyond the fourth only mark the frame as too long
  always_ff @(posedge sclk_in) begin
    if (!fresh_reg && bit_reg == 3'h7 && nbytes_reg < 3'h4) begin
      frame_reg <= {frame_reg[23:0], byte_next};
    end
  end

  // ==========================================================
  // frame end: cs_n rises, sclk may be stopped, so decode in mclk
  logic [2:0] cs_sync_reg;
  logic       cs_sync;
  assign cs_sync = cs_sync_reg[1];

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cs_sync_reg <= 3'b111;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1], cs_sync_reg[0], cs_n_in};
    end
  end

  // frame registers are stable while cs_n is high (two syncs later)
  frsg_cmd_type cmd;
  always_comb begin
    cmd = FRSG_CMD_NONE;
    if (nbytes_reg != 3'h0 && frame_reg[8*(nbytes_reg-3'h1) +: 8] == FRSG_OP_RESUME
        && nbytes_reg <= 3'h4 && bit_reg == 3'h0) begin
      cmd = FRSG_CMD_RESUME;
    end
    // a frame over four bytes would index past the kept bytes
    if (nbytes_reg >= 3'h1 && nbytes_reg <= 3'h4 && bit_reg == 3'h0
        && frame_reg[8*(nbytes_reg-3'h1) +: 8] == FRSG_OP_SUSPEND) begin
      cmd = FRSG_CMD_SUSPEND;
    end
    // only exact four byte frames count
    if (nbytes_reg == 3'h4 && bit_reg == 3'h0 &&
        frame_reg[31:8] == {FRSG_OP_PROT_B0, FRSG_OP_PROT_B1, FRSG_OP_PROT_B2}) begin
      if (frame_reg[7:0] == FRSG_OP_PROT_EN) begin
        cmd = FRSG_CMD_ENABLE;
      end
      if (frame_reg[7:0] == FRSG_OP_PROT_DS) begin
        cmd = FRSG_CMD_DISABLE;
      end
    end
  end

  logic         frame_end;
  frsg_cmd_type cmd_reg;
  assign frame_end = cs_sync && !cs_sync_reg[2];

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cmd_reg <= FRSG_CMD_NONE;
    end else begin
      cmd_reg <= frame_end ? cmd : FRSG_CMD_NONE;
    end
  end

  // ==========================================================
  // write protect pin: sync then glitch filter
  logic [1:0] wp_sync_reg;
  logic [3:0] wp_cnt_reg;
  logic       wp_low_reg;
  logic       wp_pin;

  // pad pull-up: floating pin reads deasserted
  assign wp_pin = wp_n_in | ~wp_n_pulled_in;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wp_sync_reg <= 2'b11;
    end else begin
      wp_sync_reg <= {wp_sync_reg[0], wp_pin};
    end
  end

  // level must hold before it is taken
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wp_cnt_reg <= 4'h0;
      wp_low_reg <= 1'b0;
    end else if (wp_sync_reg[1] == !wp_low_reg) begin
      wp_cnt_reg <= 4'h0;
    end else if (wp_cnt_reg == 4'(FRSG_FILTER_CYC - 1)) begin
      wp_cnt_reg <= 4'h0;
      wp_low_reg <= !wp_sync_reg[1];
    end else begin
      wp_cnt_reg <= wp_cnt_reg + 4'h1;
    end
  end

  // ==========================================================
  // software protection and the combined guard
  logic sw_prot_reg;
  logic guard_on;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sw_prot_reg <= FRSG_SW_PROT_RST;
    end else if (cmd_reg == FRSG_CMD_ENABLE) begin
      sw_prot_reg <= 1'b1;
    end else if (cmd_reg == FRSG_CMD_DISABLE && !wp_low_reg) begin
      sw_prot_reg <= 1'b0;
    end
  end

  // release keeps guard if software enabled
  assign guard_on = sw_prot_reg | wp_low_reg;

  // sector guarded when its byte is all ones
  // register itself locked while pin low
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      write_refused_out <= 1'b0;
    end else begin
      write_refused_out <= spr_write_in ? wp_low_reg
                         : (guard_on && sect_byte_in == FRSG_SECT_PROT);
    end
  end

  // ==========================================================
  // resume sequencing
  typedef enum logic [1:0] {
    FRSG_ST_IDLE = 2'b00,
    FRSG_ST_WAIT = 2'b01,
    FRSG_ST_RUN  = 2'b11
  } frsg_state_type;

  frsg_state_type st_reg;
  logic [31:0]    res_cnt_reg;
  logic           prog_first;

  assign prog_first = prog_susp_a_in | prog_susp_b_in;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      st_reg           <= FRSG_ST_IDLE;
      res_cnt_reg      <= 32'h0;
      resume_prog_out  <= 1'b0;
      resume_erase_out <= 1'b0;
    end else begin
      resume_prog_out  <= 1'b0;
      resume_erase_out <= 1'b0;
      case (st_reg)
        FRSG_ST_IDLE: begin
          if (cmd_reg == FRSG_CMD_RESUME && (prog_first || erase_susp_in)) begin
            st_reg      <= FRSG_ST_WAIT;
            res_cnt_reg <= 32'h0;
          end
        end
        FRSG_ST_WAIT: begin
          // restart issued before the latency ends
          // latency runs from deselect, so the sync and decode cycles
          // already spent are taken off the wait
          res_cnt_reg <= res_cnt_reg + 32'h1;
          if (res_cnt_reg == 32'(RESUME_CYC - FRSG_DESEL_CYC - 2)
              || RESUME_CYC < FRSG_DESEL_CYC + 2) begin
            resume_prog_out  <= prog_first;
            resume_erase_out <= !prog_first;
            st_reg           <= FRSG_ST_RUN;
          end
        end
        FRSG_ST_RUN: begin
          if (op_done_in) begin
            st_reg <= FRSG_ST_IDLE;
          end
        end
        default: st_reg <= FRSG_ST_IDLE;
      endcase
    end
  end

  // suspend dropped while resume in progress
  // host side: poll busy before suspending again
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      suspend_out <= 1'b0;
    end else begin
      suspend_out <= cmd_reg == FRSG_CMD_SUSPEND && st_reg != FRSG_ST_WAIT;
    end
  end

  // ==========================================================
  // status bits
  // suspend flag cleared, busy shown during resume
  // guard state reported from either source
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      status_out <= '{rdy_busy_n: 1'b1, default: 1'b0};
    end else begin
      status_out.rdy_busy_n          <= st_reg == FRSG_ST_IDLE;
      status_out.prog_suspend_flag_a <= prog_susp_a_in && !(resume_prog_out
                                         || (st_reg == FRSG_ST_RUN && prog_first));
      status_out.prog_suspend_flag_b <= prog_susp_b_in && !(resume_prog_out
                                         || (st_reg == FRSG_ST_RUN && prog_first));
      status_out.erase_suspend_flag  <= erase_susp_in && !(resume_erase_out
                                         || (st_reg == FRSG_ST_RUN && !prog_first));
      status_out.guard_on            <= guard_on;
    end
  end

endmodule // frsg_core

/* core/frsg_pkg.sv */
/*
  Package for the flash resume and sector guard block: command bytes,
  latency figures and their cycle counts, the suspend state carrier type.
  Assumes a 125 MHz system clock.
*/
package frsg_pkg;

  // ==========================================================
  // command bytes
  localparam logic [7:0] FRSG_OP_RESUME  = 8'hD0;
  localparam logic [7:0] FRSG_OP_PROT_B0 = 8'h3D;
  localparam logic [7:0] FRSG_OP_PROT_B1 = 8'h2A;
  localparam logic [7:0] FRSG_OP_PROT_B2 = 8'h7F;
  localparam logic [7:0] FRSG_OP_PROT_EN = 8'hA9;
  localparam logic [7:0] FRSG_OP_PROT_DS = 8'h9A;
  localparam logic [7:0] FRSG_OP_SUSPEND = 8'hB0;

  // ==========================================================
  // sectors and the protection register byte codes
  localparam int         FRSG_SECTORS    = 64;
  localparam logic [7:0] FRSG_SECT_PROT  = 8'hFF;
  localparam logic [7:0] FRSG_SECT_OPEN  = 8'h00;

  // ==========================================================
  // timing: figures in ns, counts in mclk cycles (8 ns period)
  localparam int FRSG_CLK_NS          = 8;
  localparam int FRSG_RESUME_NS       = 50000;
  localparam int FRSG_GUARD_ASSERT_NS = 100;
  localparam int FRSG_GUARD_REL_NS    = 100;
  localparam int FRSG_FILTER_NS       = 40;
  // longest times round down, least at least one cycle
  localparam int FRSG_RESUME_CYC  = FRSG_RESUME_NS / FRSG_CLK_NS;
  localparam int FRSG_FILTER_CYC  = (FRSG_FILTER_NS + FRSG_CLK_NS - 1) / FRSG_CLK_NS;
  localparam int FRSG_ASSERT_CYC  = FRSG_GUARD_ASSERT_NS / FRSG_CLK_NS;
  localparam int FRSG_REL_CYC     = FRSG_GUARD_REL_NS / FRSG_CLK_NS;
  // cs_n sync plus decode, spent before the resume wait starts
  localparam int FRSG_DESEL_CYC   = 4;

  // ==========================================================
  // reset values
  localparam logic FRSG_SW_PROT_RST = 1'b0;

  // suspend / busy state and guard state reported in the status register
  typedef struct packed {
    logic rdy_busy_n;
    logic prog_suspend_flag_a;
    logic prog_suspend_flag_b;
    logic erase_suspend_flag;
    logic guard_on;
  } frsg_status_type;

  // frame result carried from the link domain
  typedef enum logic [2:0] {
    FRSG_CMD_NONE    = 3'b000,
    FRSG_CMD_RESUME  = 3'b001,
    FRSG_CMD_ENABLE  = 3'b011,
    FRSG_CMD_DISABLE = 3'b010,
    FRSG_CMD_SUSPEND = 3'b110
  } frsg_cmd_type;

endpackage

/* verification/frsg_host_model.sv */
/*
  Host side model: sends whole-byte frames, msb first, on its own link clock.
  Assumes the caller leaves the model idle between frames.
*/
`timescale 1ns/1ps
module frsg_host_model (
  output logic sclk_out, // link clock, still outside frames
  output logic cs_n_out, // chip select, low active
  output logic si_out    // serial data
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    si_out   = 1'b1;
  end
  // ==========================================================
  // frame sender
  // whole bytes, msb first
  task automatic send(input int nbits, input logic [31:0] v);
    cs_n_out = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      si_out = v[i];
      #7.5 sclk_out = 1'b1;
      #7.5 sclk_out = 1'b0;
    end
    #7.5 cs_n_out = 1'b1;
    // released line shows the inverse, not a held value
    si_out = ~si_out;
    #60;
  endtask
endmodule // frsg_host_model

/* verification/frsg_core_checker.sv */
/*
  Port checker for frsg_core.
  Assumes binding into frsg_core; one clock domain at mclk.
*/
`timescale 1ns/1ps
module frsg_core_checker
  import frsg_pkg::*;
#(
  parameter int RESUME_CYC = 20
) (
  input wire logic            mclk_in,           // clock
  input wire logic            srst_in,           // reset
  input wire logic            wp_n_in,           // pin
  input wire logic            wp_n_pulled_in,    // pad present
  input wire logic            prog_susp_a_in,    // program a suspended
  input wire logic            prog_susp_b_in,    // program b suspended
  input wire logic [7:0]      sect_byte_in,      // protection byte
  input wire logic            spr_write_in,      // register write
  input wire logic            resume_prog_out,   // resume program
  input wire logic            resume_erase_out,  // resume erase
  input wire logic            suspend_out,       // suspend taken
  input wire logic            write_refused_out, // refused
  input wire frsg_status_type status_out         // status
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  logic        wait_reg;
  logic [31:0] wait_cnt_reg;
  // counter, since the wait may be far longer than a delay range allows
  always_ff @(posedge mclk_in) begin
    if (srst_in || !wait_reg) wait_cnt_reg <= 32'h0;
    else wait_cnt_reg <= wait_cnt_reg + 32'h1;
  end
  // ==========================================================
  // resume window tracker
  always_ff @(posedge mclk_in) begin
    if (srst_in) wait_reg <= 1'b0;
    else if (resume_prog_out || resume_erase_out) wait_reg <= 1'b0;
    else if ($fell(status_out.rdy_busy_n)) wait_reg <= 1'b1;
  end
  a_pulse_single: assert property (resume_prog_out |=> !resume_prog_out && !resume_erase_out)
    else $error("resume pulse longer than one cycle");
  a_erase_after_prog: assert property (resume_erase_out |-> !prog_susp_a_in && !prog_susp_b_in)
    else $error("erase resumed while program suspended");
  a_busy_on_resume: assert property (resume_prog_out |-> $past(!status_out.rdy_busy_n))
    else $error("resume without busy shown");
  a_flag_clears: assert property ($rose(resume_prog_out) |-> ##[1:4] !status_out.prog_suspend_flag_a)
    else $error("program suspend flag not cleared");
  a_resume_in_time: assert property (wait_cnt_reg <= 32'(RESUME_CYC))
    else $error("resume late");
  a_suspend_in_wait: assert property (!(wait_reg && suspend_out))
    else $error("suspend taken during resume");
  a_open_sector_ok: assert property ($past(sect_byte_in) == FRSG_SECT_OPEN && !$past(spr_write_in) |-> !write_refused_out)
    else $error("open sector refused");
  a_guard_latency: assert property ((!wp_n_in && wp_n_pulled_in)[*8] |-> ##[0:6] status_out.guard_on)
    else $error("pin did not raise guard");
  c_prog: cover property (resume_prog_out);
  c_erase: cover property (resume_erase_out);
  c_refused: cover property (write_refused_out);
endmodule // frsg_core_checker

bind frsg_core frsg_core_checker #(.RESUME_CYC(RESUME_CYC)) i_frsg_core_checker (
  .mclk_in(mclk_in), .srst_in(srst_in), .wp_n_in(wp_n_in), .wp_n_pulled_in(wp_n_pulled_in),
  .prog_susp_a_in(prog_susp_a_in), .prog_susp_b_in(prog_susp_b_in),
  .sect_byte_in(sect_byte_in), .spr_write_in(spr_write_in),
  .resume_prog_out(resume_prog_out), .resume_erase_out(resume_erase_out),
  .suspend_out(suspend_out), .write_refused_out(write_refused_out), .status_out(status_out));

/* verification/tb.sv */
/*
  Testbench for frsg_core: guard commands, pin, resume sequencing.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
module tb;
  import frsg_pkg::*;
  localparam int RC = 60;
  logic mclk_in, srst_in, sclk, cs_n, si, wp_n, pull, sa, sb, se, done, spr, rp, re, su, rf;
  logic [5:0] addr;
  logic [7:0] sbyte;
  frsg_status_type st;
  int fail_count = 0, samples_checked = 0, cyc = 0, np = 0, ne = 0, ns = 0;
  localparam logic [31:0] EN = {FRSG_OP_PROT_B0, FRSG_OP_PROT_B1, FRSG_OP_PROT_B2, FRSG_OP_PROT_EN};
  localparam logic [31:0] DS = {FRSG_OP_PROT_B0, FRSG_OP_PROT_B1, FRSG_OP_PROT_B2, FRSG_OP_PROT_DS};
  frsg_host_model i_frsg_host_model (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si));
  frsg_core #(.RESUME_CYC(RC)) i_frsg_core (.mclk_in(mclk_in), .srst_in(srst_in),
    .sclk_in(sclk), .cs_n_in(cs_n), .si_in(si), .wp_n_in(wp_n), .wp_n_pulled_in(pull),
    .prog_susp_a_in(sa), .prog_susp_b_in(sb), .erase_susp_in(se), .op_done_in(done),
    .sect_addr_in(addr), .sect_byte_in(sbyte), .spr_write_in(spr), .resume_prog_out(rp),
    .resume_erase_out(re), .suspend_out(su), .write_refused_out(rf), .status_out(st));
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (rp === 1'b1) np++;
    if (re === 1'b1) ne++;
    if (su === 1'b1) ns++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic pin(input logic v, input int n);
    @(posedge mclk_in) wp_n <= v;
    tick(n);
  endtask
  task automatic frame(input int nbits, input logic [31:0] v);
    i_frsg_host_model.send(nbits, v);
    tick(10);
  endtask
  task automatic t_soft;
    frame(32, EN);
    check("guard", 8'(st.guard_on), 8'h01);
    @(posedge mclk_in) sbyte <= FRSG_SECT_PROT;
    tick(3);
    check("refused", 8'(rf), 8'h01);
    @(posedge mclk_in) spr <= 1'b1;
    sbyte <= FRSG_SECT_OPEN;
    tick(3);
    check("reg refused", 8'(rf), 8'h00);
    @(posedge mclk_in) spr <= 1'b0;
    frame(32, {DS[31:8], 8'h9B});
    check("guard", 8'(st.guard_on), 8'h01);
    frame(32, DS);
    check("guard", 8'(st.guard_on), 8'h00);
    $display("t_soft done");
  endtask
  task automatic t_pin;
    pin(1'b0, 1);
    pin(1'b1, 12);
    check("glitch", 8'(st.guard_on), 8'h00);
    @(posedge mclk_in) pull <= 1'b0;
    pin(1'b0, 20);
    check("floating", 8'(st.guard_on), 8'h00);
    @(posedge mclk_in) pull <= 1'b1;
    spr <= 1'b1;
    tick(20);
    check("guard", 8'(st.guard_on), 8'h01);
    check("reg refused", 8'(rf), 8'h01);
    @(posedge mclk_in) spr <= 1'b0;
    frame(32, DS);
    check("guard", 8'(st.guard_on), 8'h01);
    pin(1'b1, 20);
    check("release", 8'(st.guard_on), 8'h00);
    frame(32, EN);
    pin(1'b0, 20);
    pin(1'b1, 20);
    check("kept", 8'(st.guard_on), 8'h01);
    frame(32, DS);
    check("guard", 8'(st.guard_on), 8'h00);
    $display("t_pin done");
  endtask
  task automatic t_resume;
    int n;
    n = 0;
    @(posedge mclk_in) sa <= 1'b1;
    se <= 1'b1;
    tick(4);
    frame(16, {16'h0, FRSG_OP_RESUME, 8'h55});
    check("busy_n", 8'(st.rdy_busy_n), 8'h00);
    frame(8, 32'(FRSG_OP_SUSPEND));
    // poll for the restart before suspending
    while (np == 0 && n < RC + 20) begin
      tick(1);
      n++;
    end
    check("prog", 8'(np), 8'h01);
    check("erase", 8'(ne), 8'h00);
    check("suspend", 8'(ns), 8'h00);
    check("flag a run", 8'(st.prog_suspend_flag_a), 8'h00);
    @(posedge mclk_in) sa <= 1'b0;
    tick(4);
    check("flag a", 8'(st.prog_suspend_flag_a), 8'h00);
    frame(8, 32'(FRSG_OP_SUSPEND));
    check("suspend", 8'(ns), 8'h01);
    @(posedge mclk_in) done <= 1'b1;
    @(posedge mclk_in) done <= 1'b0;
    frame(8, 32'(FRSG_OP_RESUME));
    tick(RC);
    check("erase", 8'(ne), 8'h01);
    check("flag e run", 8'(st.erase_suspend_flag), 8'h00);
    @(posedge mclk_in) se <= 1'b0;
    tick(4);
    check("flag e", 8'(st.erase_suspend_flag), 8'h00);
    $display("t_resume done");
  endtask
  initial begin
    {srst_in, wp_n, pull} = 3'b111;
    {sa, sb, se, done, spr} = 5'h00;
    addr = 6'h05;
    sbyte = FRSG_SECT_OPEN;
    repeat (12) @(posedge mclk_in);
    srst_in <= 1'b0;
    tick(2);
    check("busy_n", 8'(st.rdy_busy_n), 8'h01);
    check("guard", 8'(st.guard_on), 8'h00);
    $display("t_reset done");
    t_soft();
    t_pin();
    t_resume();
    give_verdict();
  end
endmodule // tb
